// File: inc/sff_defines.svh
// Timing counts, levels and field constants of the fiducial formatter
`ifndef SFF_DEFINES_SVH
`define SFF_DEFINES_SVH

// ****************************************************************
// Word levels
// ****************************************************************
`define SFF_LEVEL_HI 8'hFF
`define SFF_LEVEL_LO 8'h00
`define SFF_LOW_NIBBLE 8'h0F

// ****************************************************************
// Marker timing, counted in word times and in runs
// ****************************************************************
`define SFF_MARK_DELAY 4'h2
`define SFF_MARK_RUN_LAST 6'h2F
`define SFF_MID_LAST_PHASE 2'h1
`define SFF_END_LAST_PHASE 2'h3

// ****************************************************************
// Line-length field
// ****************************************************************
`define SFF_LL_REP_LAST 3'h5
`define SFF_LL_BIT_LAST 5'h1F
`define SFF_LL_FRAMES 2'h2
`define SFF_NOM_SECOND 20'h2_758D
`define SFF_NOM_FIRST 20'h2_758C

// ****************************************************************
// Post-amble
// ****************************************************************
`define SFF_POST_FRAME_LAST 10'h3BF
`define SFF_FILL_SKIP 48

// ****************************************************************
// Pseudo-noise generators
// ****************************************************************
`define SFF_PN_WIDTH 15
`define SFF_PN_TAPS 15'h6000
`define SFF_ENC_SEED 15'h7FFF
`define SFF_FILL_SEED 15'h7FFF
`define SFF_SUB_SEED 15'h0001

`endif

// File: inc/sff_pkg.sv
// Types shared by the fiducial formatter modules
package sff_pkg;

  // ****************************************************************
  // Slot kinds of an incoming word
  // ****************************************************************
  typedef enum logic [2:0] {
    SFF_SLOT_VIDEO = 3'h0,
    SFF_SLOT_MAJ_SYNC = 3'h1,
    SFF_SLOT_MNF_SYNC = 3'h2,
    SFF_SLOT_THERMAL = 3'h3,
    SFF_SLOT_PAYLOAD = 3'h4,
    SFF_SLOT_COUNTER = 3'h5,
    SFF_SLOT_UNUSED = 3'h6
  } sff_slot_t;

  // ****************************************************************
  // Marker sequencer states
  // ****************************************************************
  typedef enum logic [4:0] {
    SFF_ST_IDLE = 5'h01,
    SFF_ST_MID_WAIT = 5'h02,
    SFF_ST_MID_RUN = 5'h04,
    SFF_ST_END_WAIT = 5'h08,
    SFF_ST_END_RUN = 5'h10
  } sff_state_t;

endpackage : sff_pkg

// File: inc/sff_word_if.sv
// Word stream carrier between formatter core and output buffer
`timescale 1ns/10ps
interface sff_word_if #(
  parameter int W = 8
);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : sff_word_if

// File: logic/sff_pn_gen.sv
// Pseudo-noise generator delivering one word of bits per step
`timescale 1ns/10ps
`include "sff_defines.svh"
module sff_pn_gen #(
  parameter int W = `SFF_PN_WIDTH,
  parameter logic [W-1:0] TAPS = `SFF_PN_TAPS,
  parameter logic [W-1:0] SEED = `SFF_ENC_SEED,
  parameter int SKIP = 0,
  parameter int OW = 8
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic restart,
  input wire logic step,
  output logic [OW-1:0] word
);

  // ****************************************************************
  // Shift helpers
  // ****************************************************************
  function automatic logic [W-1:0] sff_adv(input logic [W-1:0] s,
                                           input int n);
    logic [W-1:0] t;
    t = s;
    for (int i = 0; i < n; i++) begin
      t = {t[W-2:0], ^(t & TAPS)};
    end
    return t;
  endfunction : sff_adv

  // Skip is folded in at elaboration, so a restart costs no cycles
  localparam logic [W-1:0] LOAD = sff_adv(SEED, SKIP);

  logic [W-1:0] state_r;
  logic [W-1:0] state_nxt;
  logic [W-1:0] cur;

  // ****************************************************************
  // Next state and word bits
  // ****************************************************************
  always_comb begin
    logic [W-1:0] t;
    t = '0;
    cur = restart ? LOAD : state_r;
    t = cur;
    word = '0;
    for (int i = 0; i < OW; i++) begin
      word[OW-1-i] = t[W-1];
      t = {t[W-2:0], ^(t & TAPS)};
    end
    state_nxt = step ? t : state_r;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= LOAD;
    end else begin
      state_r <= state_nxt;
    end
  end

endmodule : sff_pn_gen

// File: logic/sff_skid_buf.sv
// Two-entry buffer with registered output in front of the downlink
`timescale 1ns/10ps
module sff_skid_buf #(
  parameter int W = 8
) (
  input wire logic core_clk,
  input wire logic reset_n,
  sff_word_if.snk up,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  logic main_v_r;
  logic main_v_nxt;
  logic [W-1:0] main_d_r;
  logic [W-1:0] main_d_nxt;
  logic skid_v_r;
  logic skid_v_nxt;
  logic [W-1:0] skid_d_r;
  logic [W-1:0] skid_d_nxt;
  logic push;
  logic room_r;

  // Ready comes from a flop, so no path from the downlink to the source
  assign up.ready = room_r;
  assign push = up.valid & ~skid_v_r;
  assign out_data = main_d_r;
  assign out_valid = main_v_r;

  always_comb begin
    main_v_nxt = main_v_r;
    main_d_nxt = main_d_r;
    skid_v_nxt = skid_v_r;
    skid_d_nxt = skid_d_r;
    if (!main_v_r || out_ready) begin
      if (skid_v_r) begin
        main_v_nxt = 1'b1;
        main_d_nxt = skid_d_r;
        skid_v_nxt = 1'b0;
      end else begin
        main_v_nxt = push;
        main_d_nxt = up.data;
      end
    end else if (push) begin
      skid_v_nxt = 1'b1;
      skid_d_nxt = up.data;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      main_v_r <= 1'b0;
      main_d_r <= '0;
      skid_v_r <= 1'b0;
      skid_d_r <= '0;
      room_r <= 1'b1;
    end else begin
      main_v_r <= main_v_nxt;
      main_d_r <= main_d_nxt;
      skid_v_r <= skid_v_nxt;
      skid_d_r <= skid_d_nxt;
      room_r <= ~skid_v_nxt;
    end
  end

endmodule : sff_skid_buf

// File: logic/sff_formatter.sv
// Scan fiducial formatter: markers, line length, post-amble, encoding
//
// Summary of operation
// - Enabled mid-scan: 48 words 255, 48 words 0
// - Mid-scan starts two to nine words after center
// - Mid-scan displaces only video, at word boundaries
// - End-scan always: runs of 0,255,0,255, 48 each
// - End-scan starts two to nine words, video only
// - Markers and line-length words are encoded
// - Line length fills two frames after end-scan frame
// - 32 bits, each repeated six words, 192 total
// - Line length skips sync, thermal, processor, counter
// - Fields: second-half error, first-half error vs nominal
// - Sign plus 11 bits, MSB first, two's complement
// - Direction field all ones forward, zeros reverse
// - Post-amble from 960th frame until major sync
// - Post-amble keeps sync, thermal, payload, counter; fills video and spare
// - Inverted fill starts bit 49, restarts each frame
// - Encode: invert low four bits, XOR noise
// - Encoder noise reset and aligned each minor frame
// - Major and minor sync words bypass encoder
// - No instrument data: substitute maximal-length noise
`timescale 1ns/10ps
`include "sff_defines.svh"
module sff_formatter #(
  parameter int WW = 8,
  parameter int CW = 20,
  parameter int PNW = `SFF_PN_WIDTH,
  parameter logic [PNW-1:0] PN_TAPS = `SFF_PN_TAPS,
  parameter logic [PNW-1:0] ENC_SEED = `SFF_ENC_SEED,
  parameter logic [PNW-1:0] FILL_SEED = `SFF_FILL_SEED,
  parameter logic [PNW-1:0] SUB_SEED = `SFF_SUB_SEED
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [WW-1:0] in_word,
  input wire sff_pkg::sff_slot_t in_slot,
  input wire logic in_frame_start,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic mid_scan_pulse,
  input wire logic end_scan_pulse,
  input wire logic mid_scan_enable,
  input wire logic substitute_mode,
  input wire logic [CW-1:0] second_half_count,
  input wire logic [CW-1:0] first_half_count,
  input wire logic sweep_forward,
  output logic [WW-1:0] out_word,
  output logic out_valid,
  input wire logic out_ready
);

  // ****************************************************************
  // Encoder
  // ****************************************************************
  function automatic logic [WW-1:0] sff_encode(input logic [WW-1:0] w,
                                               input logic [WW-1:0] pn);
    return (w ^ WW'(`SFF_LOW_NIBBLE)) ^ pn;
  endfunction : sff_encode

  function automatic logic [WW-1:0] sff_level(input logic hi);
    return hi ? WW'(`SFF_LEVEL_HI) : WW'(`SFF_LEVEL_LO);
  endfunction : sff_level

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  localparam int NP = 4;
  logic [NP-1:0] pin_raw;
  logic [NP-1:0] s1_r;
  logic [NP-1:0] s2_r;
  logic [NP-1:0] s3_r;
  logic [NP-1:0] filt_r;
  logic [NP-1:0] filt_nxt;
  logic [NP-1:0] filt_d_r;
  logic mid_evt;
  logic end_evt;
  logic mid_en;
  logic sub_on;

  assign pin_raw = {substitute_mode, mid_scan_enable, end_scan_pulse,
                    mid_scan_pulse};

  // A level counts only once the second and third stages agree
  always_comb begin
    filt_nxt = (filt_r & ~(s2_r ~^ s3_r)) | (s2_r & (s2_r ~^ s3_r));
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      filt_r <= '0;
      filt_d_r <= '0;
    end else begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      filt_r <= filt_nxt;
      filt_d_r <= filt_r;
    end
  end

  assign mid_evt = filt_r[0] & ~filt_d_r[0];
  assign end_evt = filt_r[1] & ~filt_d_r[1];
  assign mid_en = filt_r[2];
  assign sub_on = filt_r[3];

  // ****************************************************************
  // Word handshake and slot decode
  // ****************************************************************
  sff_word_if #(.W(WW)) core_if ();

  logic take;
  logic is_video;
  logic is_sync;
  logic is_fillable;
  logic frame_take;

  assign in_ready = core_if.ready;
  assign take = in_valid & core_if.ready;
  assign is_video = (in_slot == sff_pkg::SFF_SLOT_VIDEO);
  assign is_sync = (in_slot == sff_pkg::SFF_SLOT_MAJ_SYNC) ||
                   (in_slot == sff_pkg::SFF_SLOT_MNF_SYNC);
  // only video and spare words are filled
  assign is_fillable = is_video || (in_slot == sff_pkg::SFF_SLOT_UNUSED);
  assign frame_take = take & in_frame_start;

  // ****************************************************************
  // Noise generators
  // ****************************************************************
  logic [WW-1:0] enc_pn;
  logic [WW-1:0] fill_pn;
  logic [WW-1:0] sub_pn;

  // encoder noise restarts at each minor frame
  sff_pn_gen #(.W(PNW), .TAPS(PN_TAPS), .SEED(ENC_SEED), .SKIP(0),
               .OW(WW)) u_enc_pn (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .restart(frame_take),
    .step(take),
    .word(enc_pn)
  );

  // fill starts at bit 49, restarts per frame
  sff_pn_gen #(.W(PNW), .TAPS(PN_TAPS), .SEED(FILL_SEED),
               .SKIP(`SFF_FILL_SKIP), .OW(WW)) u_fill_pn (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .restart(frame_take),
    .step(take),
    .word(fill_pn)
  );

  sff_pn_gen #(.W(PNW), .TAPS(PN_TAPS), .SEED(SUB_SEED), .SKIP(0),
               .OW(WW)) u_sub_pn (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .restart(1'b0),
    .step(take),
    .word(sub_pn)
  );

  // ****************************************************************
  // Marker sequencer
  // ****************************************************************
  sff_pkg::sff_state_t st_r;
  sff_pkg::sff_state_t st_nxt;
  logic [3:0] dly_r;
  logic [3:0] dly_nxt;
  logic [5:0] run_r;
  logic [5:0] run_nxt;
  logic [1:0] phase_r;
  logic [1:0] phase_nxt;
  logic mark_sel;
  logic mark_hi;
  logic end_done;
  logic is_end;

  assign is_end = (st_r == sff_pkg::SFF_ST_END_WAIT) ||
                  (st_r == sff_pkg::SFF_ST_END_RUN);

  // marker lands only on video words
  always_comb begin
    mark_sel = 1'b0;
    case (st_r)
      sff_pkg::SFF_ST_MID_WAIT,
      sff_pkg::SFF_ST_END_WAIT: begin
        mark_sel = in_valid & is_video & (dly_r == 4'h0);
      end
      sff_pkg::SFF_ST_MID_RUN,
      sff_pkg::SFF_ST_END_RUN: begin
        mark_sel = in_valid & is_video;
      end
      default: begin
        mark_sel = 1'b0;
      end
    endcase
  end

  // mid: white then black; end: black, white, black, white
  assign mark_hi = is_end ? phase_r[0] : ~phase_r[0];

  always_comb begin
    st_nxt = st_r;
    dly_nxt = dly_r;
    run_nxt = run_r;
    phase_nxt = phase_r;
    end_done = 1'b0;
    if (take && dly_r != 4'h0) begin
      dly_nxt = dly_r - 4'h1;
    end
    if (take && mark_sel) begin
      run_nxt = run_r + 6'h01;
      if (st_r == sff_pkg::SFF_ST_MID_WAIT) begin
        st_nxt = sff_pkg::SFF_ST_MID_RUN;
      end
      if (st_r == sff_pkg::SFF_ST_END_WAIT) begin
        st_nxt = sff_pkg::SFF_ST_END_RUN;
      end
      if (run_r == `SFF_MARK_RUN_LAST) begin
        run_nxt = 6'h00;
        phase_nxt = phase_r + 2'h1;
        if (is_end && phase_r == `SFF_END_LAST_PHASE) begin
          st_nxt = sff_pkg::SFF_ST_IDLE;
          end_done = 1'b1;
        end
        if (!is_end && phase_r == `SFF_MID_LAST_PHASE) begin
          st_nxt = sff_pkg::SFF_ST_IDLE;
        end
      end
    end
    // end marker always wins and waits the same delay as mid-scan
    if (end_evt) begin
      st_nxt = sff_pkg::SFF_ST_END_WAIT;
      dly_nxt = `SFF_MARK_DELAY;
      run_nxt = 6'h00;
      phase_nxt = 2'h0;
    // armed on center only when enabled
    end else if (mid_evt && mid_en && st_r == sff_pkg::SFF_ST_IDLE) begin
      st_nxt = sff_pkg::SFF_ST_MID_WAIT;
      dly_nxt = `SFF_MARK_DELAY;
      run_nxt = 6'h00;
      phase_nxt = 2'h0;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= sff_pkg::SFF_ST_IDLE;
      dly_r <= 4'h0;
      run_r <= 6'h00;
      phase_r <= 2'h0;
    end else begin
      st_r <= st_nxt;
      dly_r <= dly_nxt;
      run_r <= run_nxt;
      phase_r <= phase_nxt;
    end
  end

  // ****************************************************************
  // Line-length field
  // ****************************************************************
  logic ll_pend_r;
  logic ll_pend_nxt;
  logic [1:0] ll_frames_r;
  logic [1:0] ll_frames_nxt;
  logic [4:0] ll_bit_r;
  logic [4:0] ll_bit_nxt;
  logic [2:0] ll_rep_r;
  logic [2:0] ll_rep_nxt;
  logic [31:0] ll_sh_r;
  logic [31:0] ll_sh_nxt;
  logic [CW-1:0] err_second;
  logic [CW-1:0] err_first;
  logic ll_sel;

  // errors against nominal; 12-bit two's complement
  assign err_second = second_half_count - `SFF_NOM_SECOND;
  assign err_first = first_half_count - `SFF_NOM_FIRST;
  // video slots only, markers keep precedence
  assign ll_sel = in_valid & is_video & ~mark_sel & (ll_frames_r != 2'h0);

  always_comb begin
    ll_pend_nxt = ll_pend_r;
    ll_frames_nxt = ll_frames_r;
    ll_bit_nxt = ll_bit_r;
    ll_rep_nxt = ll_rep_r;
    ll_sh_nxt = ll_sh_r;
    // the frame after the one that ends the marker opens it
    if (frame_take) begin
      if (ll_pend_r) begin
        ll_pend_nxt = 1'b0;
        ll_frames_nxt = `SFF_LL_FRAMES;
      end else if (ll_frames_r != 2'h0) begin
        ll_frames_nxt = ll_frames_r - 2'h1;
      end
    end
    // six words per bit, MSB first
    if (take && ll_sel) begin
      ll_rep_nxt = ll_rep_r + 3'h1;
      if (ll_rep_r == `SFF_LL_REP_LAST) begin
        ll_rep_nxt = 3'h0;
        ll_bit_nxt = ll_bit_r + 5'h01;
        ll_sh_nxt = {ll_sh_r[30:0], 1'b0};
        if (ll_bit_r == `SFF_LL_BIT_LAST) begin
          ll_frames_nxt = 2'h0;
        end
      end
    end
    if (end_done) begin
      ll_pend_nxt = 1'b1;
      ll_frames_nxt = 2'h0;
      ll_bit_nxt = 5'h00;
      ll_rep_nxt = 3'h0;
      ll_sh_nxt = {err_second[11:0], err_first[11:0],
                   {8{sweep_forward}}};
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ll_pend_r <= 1'b0;
      ll_frames_r <= 2'h0;
      ll_bit_r <= 5'h00;
      ll_rep_r <= 3'h0;
      ll_sh_r <= 32'h0000_0000;
    end else begin
      ll_pend_r <= ll_pend_nxt;
      ll_frames_r <= ll_frames_nxt;
      ll_bit_r <= ll_bit_nxt;
      ll_rep_r <= ll_rep_nxt;
      ll_sh_r <= ll_sh_nxt;
    end
  end

  // ****************************************************************
  // Post-amble
  // ****************************************************************
  logic post_arm_r;
  logic post_arm_nxt;
  logic post_on_r;
  logic post_on_nxt;
  logic [9:0] post_cnt_r;
  logic [9:0] post_cnt_nxt;
  logic fill_sel;

  assign fill_sel = post_on_r & is_fillable & ~mark_sel & ~ll_sel;

  always_comb begin
    post_arm_nxt = post_arm_r;
    post_on_nxt = post_on_r;
    post_cnt_nxt = post_cnt_r;
    // opens on the 960th frame start after the end marker
    if (frame_take && post_arm_r) begin
      if (post_cnt_r == `SFF_POST_FRAME_LAST) begin
        post_on_nxt = 1'b1;
        post_arm_nxt = 1'b0;
      end else begin
        post_cnt_nxt = post_cnt_r + 10'h001;
      end
    end
    // closed by a major sync word, on its boundary
    if (take && in_slot == sff_pkg::SFF_SLOT_MAJ_SYNC) begin
      post_on_nxt = 1'b0;
    end
    if (end_done) begin
      post_arm_nxt = 1'b1;
      post_on_nxt = 1'b0;
      post_cnt_nxt = 10'h000;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      post_arm_r <= 1'b0;
      post_on_r <= 1'b0;
      post_cnt_r <= 10'h000;
    end else begin
      post_arm_r <= post_arm_nxt;
      post_on_r <= post_on_nxt;
      post_cnt_r <= post_cnt_nxt;
    end
  end

  // ****************************************************************
  // Output word select
  // ****************************************************************
  always_comb begin
    core_if.valid = in_valid;
    // substitute noise replaces the whole stream
    if (sub_on) begin
      core_if.data = sub_pn;
    end else if (is_sync) begin
      core_if.data = in_word;
    end else if (mark_sel) begin
      core_if.data = sff_encode(sff_level(mark_hi), enc_pn);
    end else if (ll_sel) begin
      core_if.data = sff_encode(sff_level(ll_sh_r[31]), enc_pn);
    end else if (fill_sel) begin
      core_if.data = ~fill_pn;
    end else begin
      core_if.data = in_word;
    end
  end

  // Receiver stalls back up to in_ready, no word is lost
  sff_skid_buf #(.W(WW)) u_buf (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .up(core_if.snk),
    .out_data(out_word),
    .out_valid(out_valid),
    .out_ready(out_ready)
  );

endmodule : sff_formatter

// File: sim/sff_monitor.sv
// Port-level checks of the fiducial formatter and its buffer
`timescale 1ns/10ps
module sff_monitor #(
  parameter int WW = 8
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [WW-1:0] in_word,
  input wire sff_pkg::sff_slot_t in_slot,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic substitute_mode,
  input wire logic [WW-1:0] out_word,
  input wire logic out_valid,
  input wire logic out_ready
);
  logic take, give, quiet, room, prot;
  logic [2:0] occ_r, occ_nxt, sub_r, sub_nxt;
  assign take = in_valid && in_ready;
  assign give = out_valid && out_ready;
  // Mode pin is synchronised, so wait out its latency
  assign quiet = sub_r == 3'h7;
  assign room = !out_valid || out_ready;
  assign prot = in_slot == sff_pkg::SFF_SLOT_THERMAL ||
    in_slot == sff_pkg::SFF_SLOT_PAYLOAD ||
    in_slot == sff_pkg::SFF_SLOT_COUNTER;
  always_comb begin
    occ_nxt = occ_r + 3'(take) - 3'(give);
    sub_nxt = substitute_mode ? 3'h0 : (quiet ? sub_r : sub_r + 3'h1);
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      occ_r <= 3'h0;
      sub_r <= 3'h0;
    end else begin
      occ_r <= occ_nxt;
      sub_r <= sub_nxt;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  chk_sync_bypass:
    assert property (take && quiet && room &&
      (in_slot == sff_pkg::SFF_SLOT_MNF_SYNC ||
      in_slot == sff_pkg::SFF_SLOT_MAJ_SYNC)
      |=> out_valid && out_word == $past(in_word))
    else $error("sync word altered");
  chk_keep_slots:
    assert property (take && quiet && room && prot
      |=> out_valid && out_word == $past(in_word))
    else $error("protected word altered");
  chk_out_hold:
    assert property (out_valid && !out_ready |=> out_valid && $stable(out_word))
    else $error("output changed while stalled");
  chk_answer_next:
    assert property (take && room |=> out_valid)
    else $error("taken word not presented");
  chk_ready_room:
    assert property (in_ready == (occ_r < 3'h2))
    else $error("ready does not match buffer room");
  chk_occ_valid:
    assert property (out_valid == (occ_r != 3'h0))
    else $error("valid does not match buffer content");
  chk_drain_empty:
    assert property (give && !take && occ_r == 3'h1 |=> !out_valid)
    else $error("valid stays after last word");
  chk_refill_ready:
    assert property (give && !in_ready ##1 !give |-> in_ready)
    else $error("ready not restored after drain");
endmodule : sff_monitor

bind sff_formatter sff_monitor #(.WW(WW)) mon (.core_clk(core_clk),
  .reset_n(reset_n), .in_word(in_word), .in_slot(in_slot),
  .in_valid(in_valid), .in_ready(in_ready),
  .substitute_mode(substitute_mode), .out_word(out_word),
  .out_valid(out_valid), .out_ready(out_ready));

// File: sim/sff_downlink_model.sv
// Downlink receiver stand-in: paces ready and records words
`timescale 1ns/10ps
module sff_downlink_model (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic stall_en,
  input wire logic [7:0] out_word,
  input wire logic out_valid,
  output logic out_ready
);
  logic [7:0] q[$];
  logic [2:0] cnt_r = 3'h0;
  initial out_ready = 1'b1;
  // Stalls three of eight cycles, slower than the feed
  always @(posedge core_clk) begin
    cnt_r <= cnt_r + 3'h1;
    out_ready <= #1 !(stall_en && cnt_r < 3'h3);
    if (reset_n && out_valid && out_ready) q.push_back(out_word);
  end
endmodule : sff_downlink_model

// File: sim/testbench.sv
// Self-checking bench for the scan fiducial formatter
`timescale 1ns/10ps
module testbench;
  logic core_clk, reset_n, in_frame_start, in_valid, in_ready, out_ready;
  logic mid_scan_pulse, end_scan_pulse, mid_scan_enable, substitute_mode;
  logic out_valid, stall_en, refused;
  logic [7:0] in_word, out_word;
  sff_pkg::sff_slot_t in_slot;
  int fails, n_tests;
  sff_formatter uut (.core_clk(core_clk), .reset_n(reset_n),
    .in_word(in_word), .in_slot(in_slot), .in_frame_start(in_frame_start),
    .in_valid(in_valid), .in_ready(in_ready),
    .mid_scan_pulse(mid_scan_pulse), .end_scan_pulse(end_scan_pulse),
    .mid_scan_enable(mid_scan_enable), .substitute_mode(substitute_mode),
    .second_half_count(20'h0_0000), .first_half_count(20'h0_0000),
    .sweep_forward(1'b1), .out_word(out_word), .out_valid(out_valid),
    .out_ready(out_ready));
  sff_downlink_model partner (.core_clk(core_clk), .reset_n(reset_n),
    .stall_en(stall_en), .out_word(out_word), .out_valid(out_valid),
    .out_ready(out_ready));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  task automatic cmp_w(input string nm, input logic [7:0] e, g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_w
  task automatic cmp_i(input string nm, input int e, g);
    n_tests++;
    if (g != e) begin
      fails++;
      $display("BAD %s expected %0d seen %0d", nm, e, g);
    end
  endtask : cmp_i
  task automatic put(input sff_pkg::sff_slot_t s, input logic [7:0] w);
    int k;
    k = 0;
    in_slot <= s;
    in_word <= w;
    in_frame_start <= (s == sff_pkg::SFF_SLOT_MNF_SYNC);
    in_valid <= 1'b1;
    while (in_ready !== 1'b1) begin
      refused = 1'b1;
      if (++k > 64) begin
        fails++;
        wrap_up();
      end
      @(posedge core_clk);
      #1;
    end
    @(posedge core_clk);
    #1;
  endtask : put
  task automatic wait_out(input int n);
    int k;
    k = 0;
    in_valid <= 1'b0;
    while (partner.q.size() < n) begin
      if (++k > 500) begin
        fails++;
        wrap_up();
      end
      @(posedge core_clk);
      #1;
    end
  endtask : wait_out
  task automatic feed(input int nfr);
    for (int f = 0; f < nfr; f++) begin
      put(sff_pkg::SFF_SLOT_MNF_SYNC, 8'h2D);
      for (int i = 0; i < 48; i++) put(sff_pkg::SFF_SLOT_VIDEO, 8'h5A);
    end
  endtask : feed
  task automatic t_pass;
    stall_en = 1'b1;
    refused = 1'b0;
    partner.q.delete();
    for (int i = 0; i < 60; i++)
      put(i % 6 ? sff_pkg::SFF_SLOT_VIDEO : sff_pkg::SFF_SLOT_PAYLOAD,
        8'(i * 7));
    wait_out(60);
    stall_en = 1'b0;
    cmp_i("refused while full", 1, refused);
    for (int i = 0; i < 60; i++) cmp_w("pass", 8'(i * 7), partner.q[i]);
    $display("end of pass test");
  endtask : t_pass
  task automatic t_sub;
    int same;
    same = 0;
    substitute_mode = 1'b1;
    repeat (8) @(posedge core_clk);
    #1;
    partner.q.delete();
    for (int i = 0; i < 8; i++) put(sff_pkg::SFF_SLOT_MNF_SYNC, 8'h2D);
    wait_out(8);
    for (int i = 0; i < 8; i++) same += partner.q[i] === 8'h2D;
    cmp_i("noise replaces words", 1, same < 8);
    substitute_mode = 1'b0;
    repeat (8) @(posedge core_clk);
    #1;
    $display("end of substitute test");
  endtask : t_sub
  // Runs one frame apart share encoder noise, so they differ by FF
  task automatic t_marker(input logic endm, en, input int pairs);
    int first, cnt;
    first = -1;
    cnt = 0;
    mid_scan_enable = en;
    partner.q.delete();
    fork
      feed(6);
      begin
        repeat (20) @(posedge core_clk);
        #1;
        if (endm) end_scan_pulse = 1'b1;
        else mid_scan_pulse = 1'b1;
        repeat (6) @(posedge core_clk);
        #1;
        end_scan_pulse = 1'b0;
        mid_scan_pulse = 1'b0;
      end
    join
    wait_out(294);
    for (int j = 0; j < 245; j++)
      if (first < 0 && partner.q[j] !== 8'h5A &&
        (partner.q[j] ^ partner.q[j + 49]) === 8'hFF) first = j;
    for (int j = first; first >= 0 && j < first + pairs + pairs / 48; j++)
      cnt += (partner.q[j] ^ partner.q[j + 49]) === 8'hFF;
    cmp_i("marker seen", pairs > 0, first >= 0);
    if (first >= 0) begin
      cmp_i("marker start", 1, first >= 22 && first <= 29);
      cmp_i("marker runs", pairs, cnt);
      if (endm) cmp_w("len one", partner.q[197], partner.q[246]);
      if (endm) cmp_w("len zero", ~partner.q[203], partner.q[252]);
    end
    $display("end of marker test");
  endtask : t_marker
  task automatic t_post;
    partner.q.delete();
    for (int f = 0; f < 1000; f++) begin
      put(sff_pkg::SFF_SLOT_MNF_SYNC, 8'h2D);
      put(sff_pkg::SFF_SLOT_THERMAL, 8'h33);
      put(sff_pkg::SFF_SLOT_VIDEO, 8'h5A);
      put(sff_pkg::SFF_SLOT_VIDEO, 8'h5A);
    end
    put(sff_pkg::SFF_SLOT_MAJ_SYNC, 8'hE7);
    put(sff_pkg::SFF_SLOT_VIDEO, 8'h5A);
    wait_out(4002);
    cmp_w("video before fill", 8'h5A, partner.q[3830]);
    cmp_w("fill from 960th", partner.q[3962], partner.q[3834]);
    cmp_w("thermal in fill", 8'h33, partner.q[3961]);
    cmp_w("fill restart", partner.q[3962], partner.q[3966]);
    cmp_i("fill", 1, {partner.q[3962], partner.q[3963]} !== 16'h5A5A);
    cmp_w("major sync", 8'hE7, partner.q[4000]);
    cmp_w("video after major sync", 8'h5A, partner.q[4001]);
    $display("end of post-amble test");
  endtask : t_post
  initial begin
    reset_n = 1'b0;
    in_valid = 1'b0;
    in_word = 8'h00;
    in_slot = sff_pkg::SFF_SLOT_VIDEO;
    in_frame_start = 1'b0;
    mid_scan_pulse = 1'b0;
    end_scan_pulse = 1'b0;
    mid_scan_enable = 1'b0;
    substitute_mode = 1'b0;
    stall_en = 1'b0;
    refused = 1'b0;
    fails = 0;
    n_tests = 0;
    repeat (10) @(posedge core_clk);
    #1;
    reset_n = 1'b1;
    @(posedge core_clk);
    #1;
    t_pass();
    t_sub();
    t_marker(1'b0, 1'b1, 48);
    t_marker(1'b0, 1'b0, 0);
    t_marker(1'b1, 1'b0, 144);
    t_post();
    wrap_up();
  end
endmodule : testbench
